// File: wdt_pkg.sv
package wdt_pkg;
    // Register addresses in the 12-bit register space
    localparam logic [11:0] ADDR_UNLOCK_CTL = 12'hFF0;  // Write: unlock keys, read: reset status
    localparam logic [11:0] ADDR_RELOAD_UPR = 12'hFF1;  // Reload upper byte
    localparam logic [11:0] ADDR_RELOAD_MID = 12'hFF2;  // Reload middle byte
    localparam logic [11:0] ADDR_RELOAD_LOW = 12'hFF3;  // Reload low byte

    // Unlock keys
    localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    // Reload reset values
    localparam logic [7:0] RST_RELOAD_UPR = 8'h00;
    localparam logic [7:0] RST_RELOAD_MID = 8'h04;
    localparam logic [7:0] RST_RELOAD_LOW = 8'h00;

    // Counter landmarks
    localparam logic [23:0] CNT_NO_REFRESH = 24'h00_0002;  // Refresh ignored from here on
    localparam logic [23:0] CNT_ZERO       = 24'h00_0000;
    localparam logic [23:0] CNT_MAX        = 24'hFF_FFFF;

    // Watchdog tick timing: 10 kHz tick derived from the 100 MHz system clock
    localparam int unsigned CLK_SYS_HZ     = 100_000_000;
    localparam int unsigned WDT_TICK_HZ    = 10_000;
    localparam int unsigned TICK_CYCLES    = CLK_SYS_HZ / WDT_TICK_HZ;
    localparam int unsigned TICK_CNT_W     = 14;

    // Status bit positions in the reset status byte
    localparam int unsigned STAT_BIT_WDT  = 5;
    localparam int unsigned STAT_BIT_STOP = 4;

    // Lock sequence states
    typedef enum logic [2:0] {
        LK_LOCKED,
        LK_KEY1,
        LK_OPEN_UPR,
        LK_OPEN_MID,
        LK_OPEN_LOW
    } wdt_lock_type;

    // CPU register access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } wdt_regacc_type;

    // Option bits
    typedef struct packed {
        logic always_on;
        logic resp_reset;
    } wdt_opt_type;
endpackage

// File: wdt_timer.sv
module wdt_timer
    import wdt_pkg::*;
(
    input  wire logic           clk_sys_i,      // System clock, 100 MHz
    input  wire logic           rst_n_i,        // Synchronous reset, active low
    input  wire wdt_pkg::wdt_regacc_type reg_i, // CPU register access
    input  wire wdt_pkg::wdt_opt_type    opt_i, // Option bits
    input  wire logic           refresh_i,      // Refresh instruction executed, pulse
    input  wire logic           debug_i,        // On-chip debugger active, level
    input  wire logic           stop_mode_i,    // Device in stop mode, level
    output logic [7:0]          rdata_o,        // Read data, registered
    output logic                irq_o,          // Interrupt request pulse
    output logic                sys_reset_o,    // System reset request pulse
    output logic                stop_recover_o, // Stop-mode recovery request pulse
    output logic                enabled_o       // Watchdog running
);
    import wdt_pkg::*;

    logic [7:0]            rld_upr_r;   // Reload upper byte
    logic [7:0]            rld_mid_r;   // Reload middle byte
    logic [7:0]            rld_low_r;   // Reload low byte
    logic [23:0]           cnt_r;       // Live down counter
    logic [TICK_CNT_W-1:0] pre_r;       // Tick prescaler
    logic                  tick;        // One 10 kHz tick
    logic                  en_r;        // Watchdog on
    logic                  ao_seen_r;   // Always-on sampled after reset
    logic                  flag_wdt_r;  // Time-out status
    logic                  flag_stop_r; // Time-out in stop status
    logic                  timeout;     // Counter hits zero this tick
    logic                  do_reload;   // Reload this cycle
    logic                  start;       // Turn-on event
    wdt_lock_type          lock_r;      // Unlock sequence state
    logic [23:0]           reload_val;  // Concatenated reload value

    assign reload_val = {rld_upr_r, rld_mid_r, rld_low_r};

    // Prescaler: the internal RC oscillator is modelled as a 10 kHz tick
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || !en_r)
            pre_r <= '0;
        else if (pre_r == TICK_CNT_W'(TICK_CYCLES - 1))
            pre_r <= '0;
        else
            pre_r <= pre_r + 1'b1;
    end
    assign tick = en_r && (pre_r == TICK_CNT_W'(TICK_CYCLES - 1));

    // Enable: refresh or always-on option, never turned off except by reset
    assign start = !en_r && (refresh_i || (opt_i.always_on && !ao_seen_r));
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            en_r      <= 1'b0;
            ao_seen_r <= 1'b0;
        end
        else
        begin
            ao_seen_r <= 1'b1;
            if (start)
                en_r <= 1'b1;
        end
    end

    // Refresh is refused once the count has fallen to 2 or below
    assign do_reload = start
        || (en_r && (refresh_i || debug_i) && (cnt_r > CNT_NO_REFRESH));
    assign timeout = tick && !do_reload && (cnt_r == 24'h00_0001);

    // Down counter
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            cnt_r <= CNT_ZERO;
        else if (do_reload)
            cnt_r <= reload_val;
        else if (tick && cnt_r == CNT_ZERO)
            cnt_r <= CNT_MAX;
        else if (tick)
            cnt_r <= cnt_r - 1'b1;
    end

    // Responses, one-cycle pulses
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            irq_o          <= 1'b0;
            sys_reset_o    <= 1'b0;
            stop_recover_o <= 1'b0;
        end
        else
        begin
            irq_o          <= timeout && !opt_i.resp_reset && !flag_wdt_r;
            sys_reset_o    <= timeout && opt_i.resp_reset && !stop_mode_i;
            stop_recover_o <= timeout && stop_mode_i;
        end
    end

    // Status flags; a new time-out wins over the clearing read
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            flag_wdt_r  <= 1'b0;
            flag_stop_r <= 1'b0;
        end
        else if (timeout)
        begin
            flag_wdt_r  <= 1'b1;
            flag_stop_r <= stop_mode_i;
        end
        else if (reg_i.rd && reg_i.addr == ADDR_UNLOCK_CTL)
        begin
            flag_wdt_r  <= 1'b0;
            flag_stop_r <= 1'b0;
        end
    end

    // Unlock state machine; any off-sequence write relocks
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            lock_r <= LK_LOCKED;
        else if (reg_i.wr)
        begin
            unique case (lock_r)
                LK_LOCKED:
                    lock_r <= (reg_i.addr == ADDR_UNLOCK_CTL && reg_i.wdata == UNLOCK_KEY_FIRST)
                              ? LK_KEY1 : LK_LOCKED;
                LK_KEY1:
                    lock_r <= (reg_i.addr == ADDR_UNLOCK_CTL && reg_i.wdata == UNLOCK_KEY_SECOND)
                              ? LK_OPEN_UPR : LK_LOCKED;
                LK_OPEN_UPR:
                    lock_r <= (reg_i.addr == ADDR_RELOAD_UPR) ? LK_OPEN_MID : LK_LOCKED;
                LK_OPEN_MID:
                    lock_r <= (reg_i.addr == ADDR_RELOAD_MID) ? LK_OPEN_LOW : LK_LOCKED;
                LK_OPEN_LOW:
                    lock_r <= LK_LOCKED;
                default:
                    lock_r <= LK_LOCKED;
            endcase
        end
    end

    // Reload bytes, written only at their step of the sequence
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rld_upr_r <= RST_RELOAD_UPR;
            rld_mid_r <= RST_RELOAD_MID;
            rld_low_r <= RST_RELOAD_LOW;
        end
        else if (reg_i.wr)
        begin
            if (lock_r == LK_OPEN_UPR && reg_i.addr == ADDR_RELOAD_UPR)
                rld_upr_r <= reg_i.wdata;
            if (lock_r == LK_OPEN_MID && reg_i.addr == ADDR_RELOAD_MID)
                rld_mid_r <= reg_i.wdata;
            if (lock_r == LK_OPEN_LOW && reg_i.addr == ADDR_RELOAD_LOW)
                rld_low_r <= reg_i.wdata;
        end
    end

    // Read data: status at the control address, live count at reload addresses
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            rdata_o <= 8'h00;
        else
        begin
            unique case (reg_i.addr)
                ADDR_UNLOCK_CTL:
                begin
                    rdata_o                <= 8'h00;
                    rdata_o[STAT_BIT_WDT]  <= flag_wdt_r;
                    rdata_o[STAT_BIT_STOP] <= flag_stop_r;
                end
                ADDR_RELOAD_UPR: rdata_o <= cnt_r[23:16];
                ADDR_RELOAD_MID: rdata_o <= cnt_r[15:8];
                ADDR_RELOAD_LOW: rdata_o <= cnt_r[7:0];
                default:         rdata_o <= 8'h00;
            endcase
        end
    end

    // Enabled output
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            enabled_o <= 1'b0;
        else
            enabled_o <= en_r || start;
    end

    // Checks: every property watches what the design drives and carries a
    // label that names what it checks. All share the system clock and are
    // switched off while reset is held low.

    // Status byte as the CPU sees it, one cycle after a status read
    sequence s_status_shown;
        rdata_o[STAT_BIT_WDT] == $past(flag_wdt_r)
        && rdata_o[STAT_BIT_STOP] == $past(flag_stop_r);
    endsequence

    // Both status flags gone once the read has been taken
    sequence s_status_cleared;
        !flag_wdt_r && !flag_stop_r;
    endsequence

    // Interrupt response alone, with no other pulse beside it
    sequence s_irq_alone;
        irq_o && !sys_reset_o && !stop_recover_o && flag_wdt_r;
    endsequence

    // Live count one below its value of the previous cycle
    sequence s_count_stepped;
        cnt_r == $past(cnt_r) - 24'h00_0001;
    endsequence

    // A refresh above the cut-off reloads the counter on the next edge
    a_refresh_reloads: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (en_r && refresh_i && cnt_r > CNT_NO_REFRESH) |=> cnt_r == $past(reload_val))
        else $error("refresh did not reload");

    // Near the end of the count nothing but a tick may move the counter
    a_late_refresh_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (en_r && !tick && cnt_r <= CNT_NO_REFRESH) |=> cnt_r == $past(cnt_r))
        else $error("late refresh accepted");

    // After a time-out the counter runs on from all ones
    a_wrap_max: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick && !do_reload && cnt_r == CNT_ZERO) |=> cnt_r == CNT_MAX)
        else $error("counter did not wrap");

    // Interrupt response, any mode
    a_irq_on_timeout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && !opt_i.resp_reset && !flag_wdt_r) |=> irq_o && flag_wdt_r)
        else $error("missing interrupt");

    // Interrupt response in normal operation raises nothing else
    a_irq_normal: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && !opt_i.resp_reset && !flag_wdt_r && !stop_mode_i) |=> s_irq_alone)
        else $error("interrupt time-out gave a wrong response");

    // Interrupt response in stop mode: recovery, request and both flags
    a_stop_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && stop_mode_i && !opt_i.resp_reset && !flag_wdt_r)
        |=> irq_o && stop_recover_o && flag_wdt_r && flag_stop_r)
        else $error("stop-mode interrupt response incomplete");

    // A pending flag holds back a second interrupt until it has been read
    a_irq_blocked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && flag_wdt_r) |=> !irq_o)
        else $error("repeated interrupt before status read");

    // Reset response in normal operation
    a_reset_on_timeout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && opt_i.resp_reset && !stop_mode_i) |=> sys_reset_o && flag_wdt_r)
        else $error("missing system reset");

    // Stop mode always ends in a recovery, never in a system reset
    a_stop_recovery: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (timeout && stop_mode_i) |=> stop_recover_o && flag_stop_r && !sys_reset_o)
        else $error("missing stop recovery");

    // Once on, only reset turns the watchdog off
    a_stays_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        en_r |=> en_r)
        else $error("watchdog turned off");

    // Turning on loads the reload value at once
    a_first_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        start |=> en_r && cnt_r == $past(reload_val))
        else $error("first enable did not load");

    // Time-out is flagged on the tick that takes the count to zero
    a_timeout_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        timeout |=> cnt_r == CNT_ZERO)
        else $error("time-out away from zero");

    // Every tick without a reload takes exactly one off the count, except at zero, where it wraps
    a_tick_step: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick && !do_reload && cnt_r != CNT_ZERO) |=> s_count_stepped)
        else $error("tick did not step the count");

    // A write out of sequence relocks and cannot reach the low byte
    a_stray_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.wr && lock_r == LK_OPEN_MID && reg_i.addr != ADDR_RELOAD_MID)
        |=> lock_r == LK_LOCKED ##1 $stable(rld_low_r))
        else $error("stray write left sequence open");

    // Key writes move the lock only, never the stored reload value
    a_keys_no_bytes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.wr && reg_i.addr == ADDR_UNLOCK_CTL) |=> $stable(reload_val))
        else $error("key write changed reload value");

    // The open upper step takes the written byte
    a_upper_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.wr && lock_r == LK_OPEN_UPR && reg_i.addr == ADDR_RELOAD_UPR)
        |=> rld_upr_r == $past(reg_i.wdata))
        else $error("upper reload byte not taken");

    // Whatever the low step sees, the sequence is closed afterwards
    a_low_relock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.wr && lock_r == LK_OPEN_LOW) |=> lock_r == LK_LOCKED)
        else $error("sequence still open after low byte");

    // A status read shows both flags and then clears them; a time-out in the
    // same cycle is left out, since the set wins there
    a_status_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.rd && reg_i.addr == ADDR_UNLOCK_CTL && !timeout)
        |=> s_status_shown and s_status_cleared)
        else $error("status read wrong");

    // The low reload address reads back the live count
    a_count_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_i.addr == ADDR_RELOAD_LOW) |=> rdata_o == $past(cnt_r[7:0]))
        else $error("count read wrong");

    // Under the debugger the counter keeps being reloaded
    a_debug_no_timeout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (debug_i && en_r && cnt_r > CNT_NO_REFRESH) |=> cnt_r == $past(reload_val))
        else $error("debugger did not refresh");
endmodule

// File: wdt_cpu_model.sv
// CPU side of the watchdog: register cycles and the refresh instruction
module wdt_cpu_model
    import wdt_pkg::*;
(
    input  wire logic               clk_sys_i, // System clock
    input  wire logic [7:0]         rdata_i,   // Read data from the watchdog
    output wdt_pkg::wdt_regacc_type reg_o,     // Register access
    output logic                    refresh_o  // Refresh instruction pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_o     = '0;
        refresh_o = 1'b0;
    end

    // One cycle; a released bus shows inverted values so nothing stale looks valid
    task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk_sys_i);
        reg_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_sys_i);
        reg_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1 q = rdata_i;
    endtask

    // Keys then upper, middle, low; small values are raised to the minimum
    task automatic reload(input logic [23:0] v);
        logic [7:0] q;
        if (v < 24'h00_0004) v = 24'h00_0004;
        access(1'b1, ADDR_UNLOCK_CTL, UNLOCK_KEY_FIRST, q);
        access(1'b1, ADDR_UNLOCK_CTL, UNLOCK_KEY_SECOND, q);
        access(1'b1, ADDR_RELOAD_UPR, v[23:16], q);
        access(1'b1, ADDR_RELOAD_MID, v[15:8], q);
        access(1'b1, ADDR_RELOAD_LOW, v[7:0], q);
    endtask

    // Status is read before the interrupt counts as handled
    task automatic status(output logic [7:0] q);
        access(1'b0, ADDR_UNLOCK_CTL, 8'h00, q);
    endtask

    // One-cycle refresh instruction
    task automatic refresh();
        @(posedge clk_sys_i);
        refresh_o <= 1'b1;
        @(posedge clk_sys_i);
        refresh_o <= 1'b0;
    endtask
endmodule

// File: wdt_timer_tb.sv
module wdt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    logic           clk_sys_i   = 1'b0; // 100 MHz
    logic           rst_n_i     = 1'b0; // Reset, active low
    wdt_opt_type    opt         = '0;   // Option bits
    logic           stop_mode_i = 1'b0; // Stop mode level
    logic           debug       = 1'b0; // Debugger active level
    wdt_regacc_type reg_acc;            // CPU access
    logic           refresh;            // Refresh pulse
    logic [7:0]     rdata;              // Read data
    logic [7:0]     q;                  // Last value read
    logic           irq;                // Interrupt pulse
    logic           sys_reset;          // System reset pulse
    logic           stop_recover;       // Stop recovery pulse
    logic           enabled;            // Running
    int             n_mismatch = 0;     // Mismatches
    int             compares   = 0;     // Comparisons

    always #5 clk_sys_i = ~clk_sys_i;

    // Debugger is raised only briefly: a long hold would cost a time-out of cycles
    wdt_timer i_wdt_timer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_i(reg_acc),
        .opt_i(opt), .refresh_i(refresh), .debug_i(debug), .stop_mode_i(stop_mode_i),
        .rdata_o(rdata), .irq_o(irq), .sys_reset_o(sys_reset),
        .stop_recover_o(stop_recover), .enabled_o(enabled));
    wdt_cpu_model i_wdt_cpu_model (.clk_sys_i(clk_sys_i), .rdata_i(rdata),
        .reg_o(reg_acc), .refresh_o(refresh));

    // Verdict and end of run
    task automatic final_report();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Byte compare; flags are widened into it
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register read judged against a byte
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        i_wdt_cpu_model.access(1'b0, a, 8'h00, q);
        chk8(q, exp);
    endtask

    // Bounded wait for any time-out pulse, then judge {irq, reset, recovery}
    task automatic wait_evt(input logic [2:0] exp);
        int i;
        for (i = 0; i < 60000; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            if ((irq | sys_reset | stop_recover) === 1'b1) break;
        end
        if (i == 60000)
        begin
            n_mismatch++;
            final_report();
        end
        chk8({5'h00, irq, sys_reset, stop_recover}, {5'h00, exp});
    endtask

    // Reset for 4 cycles; the first edge after release shows always-on
    task automatic do_reset(input logic ao);
        @(posedge clk_sys_i);
        opt.always_on <= ao;
        rst_n_i       <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk8({7'h00, enabled}, {7'h00, ao});
    endtask

    // First refresh loads the reset reload value, read back as live count
    task automatic test_reset_values();
        i_wdt_cpu_model.refresh();
        #1;
        chk8({7'h00, enabled}, 8'h01);
        rd(ADDR_RELOAD_UPR, RST_RELOAD_UPR);
        rd(ADDR_RELOAD_MID, RST_RELOAD_MID);
        rd(ADDR_RELOAD_LOW, RST_RELOAD_LOW);
        $display("test_reset_values done");
    endtask

    // Debugger reloads without the refresh instruction; old reload then restored
    task automatic test_debug();
        i_wdt_cpu_model.reload(24'h00_0010);
        @(posedge clk_sys_i);
        debug <= 1'b1;
        @(posedge clk_sys_i);
        debug <= 1'b0;
        rd(ADDR_RELOAD_LOW, 8'h10);
        rd(ADDR_RELOAD_MID, 8'h00);
        i_wdt_cpu_model.reload(24'h00_0400);
        $display("test_debug done");
    endtask

    // Stray write relocks; keys leave status alone; low byte relocks
    task automatic test_lock();
        i_wdt_cpu_model.access(1'b1, ADDR_UNLOCK_CTL, UNLOCK_KEY_FIRST, q);
        i_wdt_cpu_model.access(1'b1, ADDR_UNLOCK_CTL, UNLOCK_KEY_SECOND, q);
        rd(ADDR_UNLOCK_CTL, 8'h00);
        i_wdt_cpu_model.access(1'b1, 12'h123, 8'h11, q);
        i_wdt_cpu_model.access(1'b1, ADDR_RELOAD_UPR, 8'h00, q);
        i_wdt_cpu_model.access(1'b1, ADDR_RELOAD_MID, 8'h00, q);
        i_wdt_cpu_model.access(1'b1, ADDR_RELOAD_LOW, 8'h04, q);
        i_wdt_cpu_model.refresh();
        rd(ADDR_RELOAD_MID, 8'h04);
        i_wdt_cpu_model.reload(24'h00_0004);
        i_wdt_cpu_model.access(1'b1, ADDR_RELOAD_LOW, 8'h08, q);
        i_wdt_cpu_model.refresh();
        rd(ADDR_RELOAD_MID, 8'h00);
        rd(ADDR_RELOAD_LOW, 8'h04);
        $display("test_lock done");
    endtask

    // Interrupt time-out: status set, cleared by its read, count wraps
    task automatic test_irq();
        wait_evt(3'b100);
        i_wdt_cpu_model.status(q);
        chk8(q, 8'h20);
        rd(ADDR_UNLOCK_CTL, 8'h00);
        repeat (10010) @(posedge clk_sys_i);
        rd(ADDR_RELOAD_UPR, 8'hFF);
        chk8({7'h00, enabled}, 8'h01);
        $display("test_irq done");
    endtask

    // Reset response in stop mode: recovery only, both status bits
    task automatic test_stop_reset();
        @(posedge clk_sys_i);
        opt.resp_reset <= 1'b1;
        stop_mode_i    <= 1'b1;
        i_wdt_cpu_model.refresh();
        rd(ADDR_RELOAD_LOW, 8'h04);
        wait_evt(3'b001);
        rd(ADDR_UNLOCK_CTL, 8'h30);
        $display("test_stop_reset done");
    endtask

    // Always-on starts at once with the reset reload value
    task automatic test_always_on();
        do_reset(1'b1);
        rd(ADDR_RELOAD_MID, RST_RELOAD_MID);
        $display("test_always_on done");
    endtask

    // Main sequence
    initial
    begin
        do_reset(1'b0);
        test_reset_values();
        test_debug();
        test_lock();
        test_irq();
        test_stop_reset();
        test_always_on();
        final_report();
    end
endmodule
